// file: include/aci_defines.svh
`ifndef ACI_DEFINES_SVH
`define ACI_DEFINES_SVH

// Timing figures, in their own units and as derived cycle counts
`define ACI_CLK_PERIOD_NS    10
`define ACI_START_SETUP_NS   30
`define ACI_START_SETUP_CYC  ((`ACI_START_SETUP_NS + `ACI_CLK_PERIOD_NS - 1) / `ACI_CLK_PERIOD_NS)
`define ACI_CONV_TICKS       56
`define ACI_BUSY_REL_TICK    2
`define ACI_SAR_START_TICK   1
`define ACI_SAR_FIRST_TICK   8
`define ACI_SAR_STEP_TICKS   4
`define ACI_SAR_LAST_TICK    52

// Status/control word fields
`define ACI_CTL_LEN_LSB      0
`define ACI_CTL_IRQEN_BIT    3
`define ACI_CTL_EMPTY_BIT    4
`define ACI_CTL_RANGE_BIT    5
`define ACI_CTL_CNT_LSB      8
`define ACI_CTL_LEN_RST      3'h7
`define ACI_CTL_IRQEN_RST    1'b0
`define ACI_CTL_BUSMODE_RST  1'b0

// Result word fields
`define ACI_RES_CODE_LSB     4
`define ACI_RES_OVER_BIT     3
`define ACI_RES_UNDER_BIT    2

`endif

// file: include/aci_pkg.sv
package aci_pkg;

  typedef logic [11:0] aci_code_t;
  typedef logic [15:0] aci_word_t;

  typedef struct packed
  {
    aci_code_t code;
    logic      over;
    logic      under;
  } aci_entry_t;

  typedef enum {CV_IDLE, CV_LOW, CV_CONV} aci_conv_st_t;

endpackage : aci_pkg

// file: include/aci_q_if.sv
`timescale 1ns/10ps
`default_nettype none

// Result queue control and view between sequencer and storage
interface aci_q_if #(
  parameter int DEPTH = 8
);
  import aci_pkg::*;
  localparam int CNT_W = $clog2(DEPTH + 1);

  logic              push;
  aci_entry_t        push_entry;
  logic              pop;
  logic              flush;
  aci_entry_t        head;
  logic [CNT_W-1:0]  count;
  logic              empty;
  logic              full;
  logic              any_oor;

  modport ctl (output push, push_entry, pop, flush, input head, count, empty, full, any_oor);
  modport store (input push, push_entry, pop, flush, output head, count, empty, full, any_oor);
endinterface : aci_q_if

`default_nettype wire

// file: rtl/aci_queue.sv
`timescale 1ns/10ps
`default_nettype none

// Result queue held in flip-flops, with a per-word range flag summary
module aci_queue #(
  parameter int DEPTH = 8
) (
  input  wire logic clk,
  input  wire logic rst,
  aci_q_if.store    q
);
  import aci_pkg::*;
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);

  aci_entry_t       mem_ff [DEPTH];
  logic [PTR_W-1:0] wr_ptr_ff;
  logic [PTR_W-1:0] rd_ptr_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [DEPTH-1:0] oor_vec;

  // Wrap a pointer at the queue depth
  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    ptr_inc = (p == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(p + 1'b1);
  endfunction : ptr_inc

  // A push into a full queue is dropped so queued words stay intact
  wire do_push = q.push && !q.full;
  wire do_pop  = q.pop && !q.empty;

  assign q.head  = mem_ff[rd_ptr_ff];
  assign q.count = cnt_ff;
  assign q.empty = (cnt_ff == '0);
  assign q.full  = (cnt_ff == CNT_W'(DEPTH));

  // Index of the word n places behind the read pointer
  function automatic logic [PTR_W-1:0] ptr_add(input logic [PTR_W-1:0] p, input int n);
    ptr_add = PTR_W'((int'(p) + n) % DEPTH);
  endfunction : ptr_add

  // Out-of-range summary covers only the words that are live
  always_comb
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      oor_vec[i] = (CNT_W'(i) < cnt_ff) && (mem_ff[ptr_add(rd_ptr_ff, i)].over
                   || mem_ff[ptr_add(rd_ptr_ff, i)].under);
    end
  end
  assign q.any_oor = |oor_vec;

  always_ff @(posedge clk)
  begin
    if (rst || q.flush)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
    end
    else
    begin
      if (do_push)
      begin
        mem_ff[wr_ptr_ff] <= q.push_entry;
        wr_ptr_ff         <= ptr_inc(wr_ptr_ff);
      end
      if (do_pop)
        rd_ptr_ff <= ptr_inc(rd_ptr_ff);
      if (do_push && !do_pop)
        cnt_ff <= CNT_W'(cnt_ff + 1'b1);
      else if (do_pop && !do_push)
        cnt_ff <= CNT_W'(cnt_ff - 1'b1);
    end
  end
endmodule : aci_queue

`default_nettype wire

// file: rtl/aci_sar.sv
`timescale 1ns/10ps
`default_nettype none

// Successive approximation register, offset binary, MSB first
module aci_sar (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             start,
  input  wire logic             step,
  input  wire logic             comp_hi,
  output aci_pkg::aci_code_t    code
);
  import aci_pkg::*;

  aci_code_t  code_ff;
  logic [3:0] bit_ff;

  wire [3:0]  nxt_bit = 4'(bit_ff - 1'b1);
  assign code = code_ff;

  // Keep the trial bit when the input sits above the trial level
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      code_ff <= 12'h000;
      bit_ff  <= 4'hb;
    end
    else if (start)
    begin
      code_ff <= 12'h800;
      bit_ff  <= 4'hb;
    end
    else if (step)
    begin
      code_ff[bit_ff] <= comp_hi;
      if (bit_ff != 4'h0)
      begin
        code_ff[nxt_bit] <= 1'b1;
        bit_ff           <= nxt_bit;
      end
    end
  end
endmodule : aci_sar

`default_nettype wire

// file: rtl/aci_conv_host.sv
`timescale 1ns/10ps
`default_nettype none
`include "aci_defines.svh"

module aci_conv_host #(
  parameter int CLK_DIV = 8,
  parameter int DEPTH   = 8
) (
  input  wire logic              SYS_CLK,
  input  wire logic              RST,
  input  wire logic              CONVERT_START_N,
  input  wire logic              COMP_HI,
  input  wire logic              RANGE_OVER,
  input  wire logic              RANGE_UNDER,
  input  wire logic              CS_N,
  input  wire logic              REG_SEL,
  input  wire logic              RESULT_READ_STROBE_N,
  input  wire logic              CONTROL_WRITE_STROBE_N,
  input  wire aci_pkg::aci_word_t DB_IN,
  output aci_pkg::aci_word_t     DB_OUT,
  output logic                   DB_OE,
  output logic                   BUSY_N,
  output logic                   FILL_LEVEL_IRQ_N,
  output logic                   HOLD,
  output aci_pkg::aci_code_t     DAC_CODE,
  output logic                   CONV_TICK
);
  import aci_pkg::*;

  localparam int DIV_W = $clog2(CLK_DIV);
  localparam int CNT_W = $clog2(DEPTH + 1);

  // Step decode on the tick index counted from the true start edge
  function automatic logic sar_step_hit(input logic [5:0] rel);
    sar_step_hit = (rel >= 6'(`ACI_SAR_FIRST_TICK)) && (rel <= 6'(`ACI_SAR_LAST_TICK))
                   && (6'(rel - 6'(`ACI_SAR_FIRST_TICK)) % 6'(`ACI_SAR_STEP_TICKS) == 6'h00);
  endfunction : sar_step_hit

  // Offset binary to two's complement: only the sign bit flips
  function automatic aci_code_t to_twos(input aci_code_t ob);
    to_twos = {~ob[11], ob[10:0]};
  endfunction : to_twos

  aci_q_if #(.DEPTH(DEPTH)) q ();

  logic [DIV_W-1:0] div_ff;
  logic             strobe_prev_ff;
  aci_conv_st_t     st_ff;
  aci_conv_st_t     nxt_st;
  logic [5:0]       raw_ff;
  logic             defer_ff;
  logic             hold_ff;
  logic             fall_pend_ff;
  logic             busy_low_ff;
  logic             over_ff;
  logic             under_ff;
  logic [2:0]       len_ff;
  logic             irq_en_ff;
  logic             bus_mode_ff;
  logic             irq_n_ff;
  aci_word_t        db_out_ff;
  logic             rd_done_ff;
  logic             wr_done_ff;
  aci_code_t        sar_code;

  // Conversion clock is a divided tick of the host-synchronous clock
  wire tick = (div_ff == DIV_W'(CLK_DIV - 1));
  wire [DIV_W-1:0] nxt_div = tick ? '0 : DIV_W'(div_ff + 1'b1);
  assign CONV_TICK = tick;

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      div_ff <= '0;
    else
      div_ff <= nxt_div;
  end

  // Strobe edge detection; inputs are synchronous to the clock
  wire strobe_rise = !strobe_prev_ff && CONVERT_START_N;
  wire strobe_fall = strobe_prev_ff && !CONVERT_START_N;

  // Cycles from the rise edge to the next tick edge after it; a tick that
  // coincides with the rise edge is never counted, so it needs no deferral
  wire [DIV_W:0] cyc_to_tick = tick ? (DIV_W + 1)'(CLK_DIV)
                             : (DIV_W + 1)'(CLK_DIV - 1) - {1'b0, div_ff};
  wire late_rise = cyc_to_tick < (DIV_W + 1)'(`ACI_START_SETUP_CYC);

  // Tick bookkeeping while converting
  wire [5:0] nxt_raw = 6'(raw_ff + 1'b1);
  wire [5:0] rel_now = 6'(nxt_raw - {5'h00, defer_ff});
  wire       in_conv = (st_ff == CV_CONV);
  wire [5:0] end_tick = 6'(`ACI_CONV_TICKS) + {5'h00, defer_ff};
  wire       conv_done = in_conv && tick && (nxt_raw == end_tick);
  wire       sar_start = in_conv && tick && (rel_now == 6'(`ACI_SAR_START_TICK));
  wire       sar_step = in_conv && tick && sar_step_hit(rel_now);
  wire       busy_rel = in_conv && tick && (nxt_raw == 6'(`ACI_BUSY_REL_TICK));

  // Sequencer: a new strobe during a conversion is ignored
  always_comb
  begin
    nxt_st = st_ff;
    unique case (st_ff)
      CV_IDLE:
        if (strobe_fall)
          nxt_st = CV_LOW;
      CV_LOW:
        if (strobe_rise)
          nxt_st = CV_CONV;
      CV_CONV:
        if (conv_done)
          nxt_st = CV_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      st_ff          <= CV_IDLE;
      strobe_prev_ff <= 1'b1;
    end
    else
    begin
      st_ff          <= nxt_st;
      strobe_prev_ff <= CONVERT_START_N;
    end
  end

  // Tick counter and deferral latched at the strobe rise
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      raw_ff   <= 6'h00;
      defer_ff <= 1'b0;
    end
    else if (st_ff == CV_LOW && strobe_rise)
    begin
      raw_ff   <= 6'h00;
      defer_ff <= late_rise;
    end
    else if (in_conv && tick)
      raw_ff <= nxt_raw;
  end

  // Hold from the strobe rise until the queue update; range caught at hold
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      hold_ff  <= 1'b0;
      over_ff  <= 1'b0;
      under_ff <= 1'b0;
    end
    else if (st_ff == CV_LOW && strobe_rise)
    begin
      hold_ff  <= 1'b1;
      over_ff  <= RANGE_OVER;
      under_ff <= RANGE_UNDER;
    end
    else if (conv_done)
      hold_ff <= 1'b0;
  end
  assign HOLD = hold_ff;

  // Busy: set on the first tick after the fall, cleared two ticks after rise
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      fall_pend_ff <= 1'b0;
      busy_low_ff  <= 1'b0;
    end
    else
    begin
      if (st_ff == CV_IDLE && strobe_fall)
        fall_pend_ff <= 1'b1;
      else if (tick)
        fall_pend_ff <= 1'b0;
      if (tick && fall_pend_ff)
        busy_low_ff <= 1'b1;
      else if (busy_rel)
        busy_low_ff <= 1'b0;
    end
  end
  assign BUSY_N = !busy_low_ff;

  aci_sar u_sar (
    .clk     (SYS_CLK),
    .rst     (RST),
    .start   (sar_start),
    .step    (sar_step),
    .comp_hi (COMP_HI),
    .code    (sar_code)
  );
  assign DAC_CODE = sar_code;

  // Host access gating: blocked while busy unless bus mode lets it through
  wire access_ok = !busy_low_ff || bus_mode_ff;
  wire rd_req = !CS_N && !RESULT_READ_STROBE_N;
  wire wr_req = !CS_N && !CONTROL_WRITE_STROBE_N;
  wire rd_act = rd_req && access_ok && !rd_done_ff;
  wire wr_act = wr_req && access_ok && !wr_done_ff;

  // Status word and result word as seen on the data bus
  wire [3:0] cnt4 = 4'(q.count);
  wire aci_word_t status_word = {4'h0, cnt4, 2'b00, q.any_oor, q.empty, irq_en_ff, len_ff};
  wire aci_word_t result_word = q.empty ? 16'h0000
                              : {to_twos(q.head.code), q.head.over, q.head.under, 2'b00};

  assign q.push       = conv_done;
  assign q.push_entry = '{code: sar_code, over: over_ff, under: under_ff};
  assign q.pop        = rd_act && !REG_SEL;
  assign q.flush      = wr_act;

  aci_queue #(.DEPTH(DEPTH)) u_queue (
    .clk (SYS_CLK),
    .rst (RST),
    .q   (q.store)
  );

  // Each strobe acts once; a blocked access waits with the strobe held low
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      rd_done_ff <= 1'b0;
      wr_done_ff <= 1'b0;
      db_out_ff  <= 16'h0000;
    end
    else
    begin
      rd_done_ff <= rd_req && (rd_done_ff || rd_act);
      wr_done_ff <= wr_req && (wr_done_ff || wr_act);
      if (rd_act)
        db_out_ff <= REG_SEL ? status_word : result_word;
    end
  end
  assign DB_OUT = db_out_ff;
  assign DB_OE  = rd_req && access_ok && rd_done_ff;

  // Control fields; writing also empties the queue
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      len_ff      <= `ACI_CTL_LEN_RST;
      irq_en_ff   <= `ACI_CTL_IRQEN_RST;
      bus_mode_ff <= `ACI_CTL_BUSMODE_RST;
    end
    else if (wr_act)
    begin
      len_ff      <= DB_IN[`ACI_CTL_LEN_LSB +: 3];
      irq_en_ff   <= DB_IN[`ACI_CTL_IRQEN_BIT];
      bus_mode_ff <= DB_IN[`ACI_CTL_RANGE_BIT];
    end
  end

  // Fill level: programmed field plus one words, 1 to 8
  wire [CNT_W-1:0] fill_target = CNT_W'({1'b0, len_ff} + 4'h1);
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      irq_n_ff <= 1'b1;
    else
      irq_n_ff <= !(irq_en_ff && (q.count >= fill_target));
  end
  assign FILL_LEVEL_IRQ_N = irq_n_ff;

endmodule : aci_conv_host

`default_nettype wire

// file: test/aci_conv_host_asserts.sv
`timescale 1ns/10ps
`default_nettype none

// Conversion timing and bus drive, seen from the top ports only
module aci_conv_host_asserts (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic CONVERT_START_N,
  input wire logic CS_N,
  input wire logic RESULT_READ_STROBE_N,
  input wire logic DB_OE,
  input wire logic BUSY_N,
  input wire logic FILL_LEVEL_IRQ_N,
  input wire logic HOLD,
  input wire logic CONV_TICK
);
  logic       host_common_strobe_ff;
  logic [6:0] tick_ff;
  logic [3:0] gap_ff;
  logic       arm_ff;
  // Accepted strobe rise: only while the sampler tracks
  wire        rise = CONVERT_START_N & ~host_common_strobe_ff & ~HOLD;

  // Ticks since the rise, and cycles from the rise to the first tick
  always_ff @(posedge SYS_CLK)
  begin
    host_common_strobe_ff <= CONVERT_START_N;
    if (RST || rise)
    begin
      tick_ff <= 7'h0;
      gap_ff  <= 4'h0;
      arm_ff  <= rise;
    end
    else
    begin
      if (CONV_TICK && tick_ff != 7'h7f)
        tick_ff <= tick_ff + 7'h1;
      if (arm_ff)
        gap_ff <= gap_ff + 4'h1;
      if (CONV_TICK)
        arm_ff <= 1'b0;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  a_busy_fall: assert property ($fell(BUSY_N) |-> $past(CONV_TICK) && !$past(HOLD))
    else $error("busy fell away from a tick");
  a_busy_rel: assert property ($rose(BUSY_N) |-> tick_ff == 7'h2 && $past(CONV_TICK))
    else $error("busy not released on second tick");
  a_busy_stays_high: assert property (HOLD && tick_ff > 7'h2 |-> BUSY_N)
    else $error("busy low late in conversion");
  a_hold_start: assert property (rise |-> ##[1:2] HOLD)
    else $error("sampler did not hold after strobe rise");
  a_hold_min: assert property ($rose(HOLD) |-> HOLD [*8])
    else $error("hold dropped early");
  a_conv_len: assert property ($fell(HOLD) |-> tick_ff == ((gap_ff < 4'h3) ? 7'h39 : 7'h38))
    else $error("conversion length wrong");
  a_irq_push: assert property ($fell(FILL_LEVEL_IRQ_N) |-> $past(HOLD, 2) && !$past(HOLD))
    else $error("fill interrupt not one cycle after a push");
  a_oe_select: assert property (DB_OE |-> !CS_N && !RESULT_READ_STROBE_N)
    else $error("bus driven without a read");

  c_deferred: cover property ($fell(HOLD) && gap_ff < 4'h3);
  c_prompt: cover property ($fell(HOLD) && gap_ff >= 4'h3);
  c_irq: cover property ($fell(FILL_LEVEL_IRQ_N));
endmodule : aci_conv_host_asserts

bind aci_conv_host aci_conv_host_asserts i_chk (
  .SYS_CLK(SYS_CLK), .RST(RST), .CONVERT_START_N(CONVERT_START_N), .CS_N(CS_N),
  .RESULT_READ_STROBE_N(RESULT_READ_STROBE_N), .DB_OE(DB_OE), .BUSY_N(BUSY_N),
  .FILL_LEVEL_IRQ_N(FILL_LEVEL_IRQ_N), .HOLD(HOLD), .CONV_TICK(CONV_TICK));

`default_nettype wire

// file: test/aci_afe_model.sv
`timescale 1ns/10ps
`default_nettype none

// Analog front end: track/hold, comparator and range detect
module aci_afe_model (
  input wire logic               clk,
  input wire logic               hold,
  input wire aci_pkg::aci_code_t dac_code,
  input wire aci_pkg::aci_code_t level,
  input wire logic               over,
  input wire logic               under,
  output logic                   comp_hi,
  output logic                   range_over,
  output logic                   range_under
);
  import aci_pkg::*;
  aci_code_t held_ff;

  // Follow the input while tracking, freeze it while holding
  always_ff @(posedge clk)
  begin
    if (!hold)
      held_ff <= level ^ 12'h800;
  end

  // Input sits mid-step, so the trial level never ties with it
  assign comp_hi     = {held_ff, 1'b1} > {dac_code, 1'b0};
  assign range_over  = over;
  assign range_under = under;
endmodule : aci_afe_model

`default_nettype wire

// file: test/aci_conv_host_tb.sv
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end

module aci_conv_host_tb;
  import aci_pkg::*;
  logic      clk, rst, conv_n, cs_n, reg_sel, rd_n, wr_n, db_oe, busy_n, irq_n, hold, tick;
  logic      comp, rov, run, ov, un, exp_busy_n;
  aci_word_t db_in, db_out, d;
  aci_code_t dac, level;
  aci_code_t codes [3] = '{12'h7ff, 12'h800, 12'hfff};
  int        check_count, miscompares;

  aci_conv_host #(.CLK_DIV(4), .DEPTH(8)) i_dut (
    .SYS_CLK(clk), .RST(rst), .CONVERT_START_N(conv_n), .COMP_HI(comp), .RANGE_OVER(rov),
    .RANGE_UNDER(run), .CS_N(cs_n), .REG_SEL(reg_sel), .RESULT_READ_STROBE_N(rd_n),
    .CONTROL_WRITE_STROBE_N(wr_n), .DB_IN(db_in), .DB_OUT(db_out), .DB_OE(db_oe),
    .BUSY_N(busy_n), .FILL_LEVEL_IRQ_N(irq_n), .HOLD(hold), .DAC_CODE(dac), .CONV_TICK(tick));

  aci_afe_model i_afe (
    .clk(clk), .hold(hold), .dac_code(dac), .level(level), .over(ov), .under(un),
    .comp_hi(comp), .range_over(rov), .range_under(run));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Verdict and end of run
  task automatic test_done;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  // Read: hold select and strobe until the bus is driven
  task automatic rd(input logic sel, output aci_word_t q);
    int n;
    @(posedge clk);
    cs_n    <= 1'b0;
    reg_sel <= sel;
    rd_n    <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (db_oe !== 1'b1 && n < 400);
    if (n >= 400)
    begin
      miscompares++;
      test_done();
    end
    `CHK("busy during read", exp_busy_n, busy_n)
    q = db_out;
    @(posedge clk);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
  endtask : rd

  // Control write, only issued while idle so it is never stretched
  task automatic wr(input aci_word_t v);
    @(posedge clk);
    cs_n  <= 1'b0;
    db_in <= v;
    wr_n  <= 1'b0;
    repeat (2) @(posedge clk);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
  endtask : wr

  // One conversion; the input moves while held to show the sample instant
  task automatic conv(input aci_code_t v, input logic o, input logic u, input int pre);
    int n;
    @(posedge clk);
    level <= v;
    ov    <= o;
    un    <= u;
    repeat (pre + 1) @(posedge clk);
    conv_n <= 1'b0;
    repeat (6) @(posedge clk);
    conv_n <= 1'b1;
    repeat (5) @(posedge clk);
    level <= ~v;
    n = 0;
    while (hold !== 1'b0 && n < 400)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 400)
    begin
      miscompares++;
      test_done();
    end
    repeat (2) @(posedge clk);
  endtask : conv

  initial
  begin
    rst = 1'b1; conv_n = 1'b1; cs_n = 1'b1; reg_sel = 1'b0; rd_n = 1'b1; wr_n = 1'b1;
    db_in = 16'h0; level = 12'h0; ov = 1'b0; un = 1'b0; exp_busy_n = 1'b1;
    check_count = 0;
    miscompares = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // Reset state, then fill level of three with interrupt on
    rd(1'b1, d); `CHK("status reset", 16'h0017, d)
    rd(1'b0, d); `CHK("empty read", 16'h0000, d)
    wr(16'h000a);
    rd(1'b1, d); `CHK("status ctl", 16'h001a, d)
    $display("test reset done");
    // Full-scale and around-ground codes, varied strobe alignment
    for (int i = 0; i < 3; i++)
    begin
      conv(codes[i], 1'b0, 1'b0, i);
      `CHK("fill irq", (i == 2) ? 1'b0 : 1'b1, irq_n)
    end
    rd(1'b1, d); `CHK("status three", 16'h030a, d)
    for (int i = 0; i < 3; i++)
    begin
      rd(1'b0, d); `CHK("result", {codes[i], 4'h0}, d)
    end
    rd(1'b1, d); `CHK("status drained", 16'h001a, d)
    $display("test codes done");
    // Per-word range flags, summary bit, then flush by control write
    conv(12'h7ff, 1'b1, 1'b0, 3);
    conv(12'h800, 1'b0, 1'b1, 1);
    rd(1'b1, d); `CHK("status range", 16'h022a, d)
    rd(1'b0, d); `CHK("over word", 16'h7ff8, d)
    rd(1'b1, d); `CHK("status under left", 16'h012a, d)
    wr(16'h000a);
    rd(1'b1, d); `CHK("status flushed", 16'h001a, d)
    $display("test range done");
    // Read issued while busy is low waits for its release
    fork
      conv(12'h123, 1'b0, 1'b0, 0);
      begin
        repeat (7) @(posedge clk);
        rd(1'b1, d); `CHK("stretched status", 16'h001a, d)
      end
    join
    rd(1'b0, d); `CHK("stretched result", 16'h1230, d)
    $display("test stretch done");
    // Bus mode lets the same read through while busy is still low
    wr(16'h002a);
    exp_busy_n = 1'b0;
    fork
      conv(12'h456, 1'b0, 1'b0, 0);
      begin
        repeat (7) @(posedge clk);
        rd(1'b1, d); `CHK("bus mode status", 16'h001a, d)
      end
    join
    exp_busy_n = 1'b1;
    rd(1'b0, d); `CHK("bus mode result", 16'h4560, d)
    wr(16'h000a);
    $display("test bus mode done");
    test_done();
  end
endmodule : aci_conv_host_tb

`default_nettype wire
